// ---- rtl/sims_burst_seq.sv ----
// Purpose: steps through the eight beats of a read or write burst
// Assumes: one beat per core clock, a new request restarts the burst
// Notes:   beat outputs are registered
`timescale 1ns/1ps
module sims_burst_seq
    import sims_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    reset_n_i,
    sims_burst_if.seq    bus
);

    sims_seq_t  sq_r;
    sims_seq_t  sq_nxt;
    logic [2:0] idx;
    logic       go;
    logic [1:0] low;

    // ************************************************************
    // beat ordering
    // ************************************************************
    always_comb
    begin
        sq_nxt = sq_r;
        idx    = sq_r.cnt;
        if (bus.start)
        begin
            sq_nxt.read       = bus.is_read;
            sq_nxt.chop       = bus.chop;
            sq_nxt.interleave = bus.interleave;
            sq_nxt.base       = bus.col;
            idx               = 3'h0;
        end
        go = bus.start | sq_r.run;
        // interleaved xors, sequential wraps the low two bits
        if (sq_nxt.interleave)
            low = sq_nxt.base[1:0] ^ idx[1:0];
        else
            low = sq_nxt.base[1:0] + idx[1:0];
        sq_nxt.valid = go;
        sq_nxt.drive = go & sq_nxt.read & (~sq_nxt.chop | ~idx[2]);   // chopped tail is high-z
        sq_nxt.take  = go & ~sq_nxt.read & (~sq_nxt.chop | ~idx[2]);  // chopped tail ignored
        if (go)
        begin
            if (sq_nxt.read)
                sq_nxt.beat_col = {sq_nxt.base[2] ^ (idx[2] & ~sq_nxt.chop), low};
            else if (sq_nxt.chop)
                sq_nxt.beat_col = {sq_nxt.base[2], idx[1:0]};  // write half chosen by a2
            else
                sq_nxt.beat_col = idx;                         // full write from column 0
            sq_nxt.cnt = idx + 3'h1;
            sq_nxt.run = (idx != LAST_BEAT);
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            sq_r <= '0;
        else
            sq_r <= sq_nxt;
    end

    assign bus.valid    = sq_r.valid;
    assign bus.beat_col = sq_r.beat_col;
    assign bus.drive    = sq_r.drive;
    assign bus.take     = sq_r.take;

    // ************************************************************
    // checks
    // ************************************************************
    sequence chop_tail_s;
        bus.drive [*4] ##1 (!bus.drive && bus.valid) [*4];
    endsequence

    sequence il_five_s;
        bus.beat_col == 3'h5 ##1 bus.beat_col == 3'h4 ##1 bus.beat_col == 3'h7 ##1 bus.beat_col == 3'h6;
    endsequence

    chop_read_hiz_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus.start && bus.is_read && bus.chop) ##1 (!bus.start) [*4] |=> bus.valid && !bus.drive)
        else $error("chopped read tail not high-z");
    chop_tail_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus.start && bus.is_read && bus.chop) ##1 (!bus.start) [*7] |=> bus.valid && !bus.drive && !bus.take)
        else $error("chop tail check");
    chop_shape_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus.start && bus.is_read && bus.chop && !sq_r.run) |=> chop_tail_s or bus.start [*1])
        else $error("chopped read beat pattern wrong");
    inter_order_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus.start && bus.is_read && bus.interleave && bus.col == 3'h5) ##1 (!bus.start) [*4] |->
        $past(bus.beat_col, 3) == 3'h5 && $past(bus.beat_col, 2) == 3'h4 && $past(bus.beat_col) == 3'h7
        && bus.beat_col == 3'h6)
        else $error("interleaved order wrong");
    seq_wrap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus.valid && sq_r.read && !sq_r.interleave && !sq_r.chop && sq_r.run && !bus.start) |=>
        bus.beat_col[1:0] == $past(bus.beat_col[1:0]) + 2'h1)
        else $error("sequential beat not wrapping");
    write_take_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus.start && !bus.is_read && !bus.chop) |=> bus.take && bus.beat_col == 3'h0 && !bus.drive)
        else $error("eight-beat write must start at column zero");

endmodule

// ---- rtl/sims_top.sv ----
// Purpose: reset, termination hold-off and mode-register state of a DDR DRAM device
// Assumes: command pins and clock enable synchronous to the core clock
// Notes:   bursts run one beat per core clock; registers reachable over a plain port
`timescale 1ns/1ps

// ************************************************************
// device logic
// ************************************************************
// Function
// - termination stays high-z under reset and until clock enable seen high.
// - bank code two selects register two, code three selects register three.
// - bank code one selects register one; A0 low enables the delay loop.
// - bank code zero selects register zero; A8 resets the loop; BA2, A13 zero.
// - mode set and delay-loop reset never alter stored array data.
// - register-zero bit A3 chooses sequential or interleaved burst order.
// - bits A0-A1 choose fixed chop, fixed eight or per-command selection via A12.
// - eight-beat read order from A2..A0, sequential wrap or interleaved xor.
// - chopped reads high-z last four beats; writes ignore low column bits.
module sims_top
    import sims_pkg::*;
(
    input  wire logic              CORE_CLK_I,
    input  wire logic              RESET_N_I,
    input  wire logic              CKE_I,
    input  wire logic              TERM_CTRL_I,
    input  wire logic              CS_N_I,
    input  wire logic              RAS_N_I,
    input  wire logic              CAS_N_I,
    input  wire logic              WE_N_I,
    input  wire logic [2:0]        BA_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [REG_AW-1:0] REG_ADDR_I,
    input  wire logic [REG_DW-1:0] REG_WDATA_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    output logic [REG_DW-1:0]      REG_RDATA_O,
    output logic                   TERM_ACTIVE_O,
    output logic                   DLL_ENABLE_O,
    output logic                   DLL_RESET_O,
    output logic                   BEAT_VALID_O,
    output logic [2:0]             BEAT_COL_O,
    output logic                   BEAT_DRIVE_O,
    output logic                   BEAT_TAKE_O
);

    sims_ctl_t   st_r;
    sims_ctl_t   st_nxt;
    logic        cmd_ok;
    logic        is_mset;
    logic        is_rw;
    logic        rsv_bad;
    logic [1:0]  sel;
    logic [1:0]  bl;
    logic [REG_DW-1:0] status;

    sims_burst_if bus ();

    // ************************************************************
    // command decode and state update
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        sel    = BA_I[1:0];
        bl     = st_r.mr[SEL_ZERO][BL_LSB +: 2];
        // commands count only once clock enable is registered and high
        cmd_ok  = CKE_I && st_r.cke_seen && !CS_N_I;
        is_mset = cmd_ok && !RAS_N_I && !CAS_N_I && !WE_N_I;
        is_rw   = cmd_ok && RAS_N_I && !CAS_N_I;
        // reserved bank bit or top address bit of register zero set
        rsv_bad = is_mset && (BA_I[BA_RSV_BIT] || (sel == SEL_ZERO && ADDR_I[RSV_TOP_BIT]));

        // termination released only after clock enable is seen high
        st_nxt.cke_seen = st_r.cke_seen | CKE_I;
        st_nxt.term     = (st_r.cke_seen | CKE_I) & TERM_CTRL_I;

        // mode set overwrites the whole register; array state untouched
        st_nxt.dll_rst = 1'b0;
        if (is_mset && !BA_I[BA_RSV_BIT])
        begin
            st_nxt.mr[sel]      = ADDR_I;
            st_nxt.written[sel] = 1'b1;
            if (sel == SEL_ZERO)
            begin
                st_nxt.dll_rst                     = ADDR_I[DLL_RST_BIT];
                st_nxt.mr[SEL_ZERO][DLL_RST_BIT]   = 1'b0;                  // self-clearing
            end
        end
        // delay loop enabled by A0 low in register one
        st_nxt.dll_en = st_nxt.written[SEL_ONE] & ~st_nxt.mr[SEL_ONE][DLL_OFF_BIT];

        // burst request; length from register zero or per command
        st_nxt.start      = is_rw;
        st_nxt.is_read    = WE_N_I;
        st_nxt.chop       = (bl == BL_FIXED4) || (bl == BL_OTF && !ADDR_I[CHOP_SEL_BIT]);
        st_nxt.interleave = st_r.mr[SEL_ZERO][BT_BIT];
        st_nxt.col        = ADDR_I[2:0];

        // control write and sticky error, set wins over clear
        if (REG_WR_I && REG_ADDR_I == OFF_CTRL)
            st_nxt.check_en = REG_WDATA_I[CTRL_CHECK_BIT];
        if (REG_WR_I && REG_ADDR_I == OFF_STATUS && REG_WDATA_I[STAT_ERR_BIT])
            st_nxt.err = 1'b0;
        if (rsv_bad && st_r.check_en)
            st_nxt.err = 1'b1;

        // read data valid only in the cycle after the strobe
        status                          = '0;
        status[STAT_TERM_BIT]           = st_r.term;
        status[STAT_ERR_BIT]            = st_r.err;
        status[STAT_DLL_BIT]            = st_r.dll_en;
        status[STAT_CKE_BIT]            = st_r.cke_seen;
        status[STAT_WR_LSB +: 4]        = st_r.written;
        st_nxt.rdata = '0;
        if (REG_RD_I)
        begin
            unique case (REG_ADDR_I)
                OFF_CTRL:   st_nxt.rdata = {{(REG_DW-1){1'b0}}, st_r.check_en};
                OFF_STATUS: st_nxt.rdata = status;
                OFF_MODE_ZERO:  st_nxt.rdata = {{(REG_DW-ADDR_W){1'b0}}, st_r.mr[SEL_ZERO]};
                OFF_MODE_ONE:   st_nxt.rdata = {{(REG_DW-ADDR_W){1'b0}}, st_r.mr[SEL_ONE]};
                OFF_MODE_TWO:   st_nxt.rdata = {{(REG_DW-ADDR_W){1'b0}}, st_r.mr[SEL_TWO]};
                OFF_MODE_THREE: st_nxt.rdata = {{(REG_DW-ADDR_W){1'b0}}, st_r.mr[SEL_THREE]};
                default:    st_nxt.rdata = '0;            // unmapped reads zero
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            st_r          <= '0;
            st_r.check_en <= CTRL_CHECK_RST;
        end
        else
            st_r <= st_nxt;
    end

    // burst request toward the sequencer
    assign bus.start      = st_r.start;
    assign bus.is_read    = st_r.is_read;
    assign bus.chop       = st_r.chop;
    assign bus.interleave = st_r.interleave;
    assign bus.col        = st_r.col;

    sims_burst_seq u_seq
    (
        .clk_i     (CORE_CLK_I),
        .reset_n_i (RESET_N_I),
        .bus       (bus)
    );

    // outputs straight from flip-flops
    assign REG_RDATA_O   = st_r.rdata;
    assign TERM_ACTIVE_O = st_r.term;
    assign DLL_ENABLE_O  = st_r.dll_en;
    assign DLL_RESET_O   = st_r.dll_rst;
    assign BEAT_VALID_O  = bus.valid;
    assign BEAT_COL_O    = bus.beat_col;
    assign BEAT_DRIVE_O  = bus.drive;
    assign BEAT_TAKE_O   = bus.take;

    // ************************************************************
    // checks
    // ************************************************************
    sequence mset_s (logic [1:0] code);
        is_mset && !BA_I[BA_RSV_BIT] && sel == code;
    endsequence

    term_hiz_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        !st_r.cke_seen |-> !TERM_ACTIVE_O)
        else $error("termination active before clock enable seen");
    term_reset_a: assert property (@(posedge CORE_CLK_I)
        !RESET_N_I |=> !TERM_ACTIVE_O && !st_r.cke_seen)
        else $error("termination active after reset");
    mset_two_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        mset_s(SEL_TWO) |=> st_r.mr[SEL_TWO] == $past(ADDR_I) && st_r.written[SEL_TWO])
        else $error("register two not loaded");
    mset_three_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        mset_s(SEL_THREE) |=> st_r.mr[SEL_THREE] == $past(ADDR_I) && $stable(st_r.mr[SEL_TWO]))
        else $error("register three not loaded alone");
    dll_enable_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        mset_s(SEL_ONE) |=> DLL_ENABLE_O == !$past(ADDR_I[DLL_OFF_BIT]))
        else $error("delay loop enable wrong");
    dll_pulse_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (mset_s(SEL_ZERO) and ADDR_I[DLL_RST_BIT]) ##1 !is_mset |=> !DLL_RESET_O ##0 $past(DLL_RESET_O))
        else $error("delay loop reset not a single pulse");
    dll_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        !st_r.mr[SEL_ZERO][DLL_RST_BIT])
        else $error("delay loop reset bit not self-clearing");
    rsv_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (rsv_bad && st_r.check_en) |=> st_r.err)
        else $error("reserved bit not flagged");
    rsv_ignore_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (is_mset && BA_I[BA_RSV_BIT]) |=> $stable(st_r.mr))
        else $error("reserved bank code changed a register");
    otf_chop_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (is_rw && bl == BL_OTF) |=> bus.start && bus.chop == !$past(ADDR_I[CHOP_SEL_BIT]))
        else $error("per-command chop select wrong");
    fixed_len_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (is_rw && bl == BL_FIXED8) |=> !bus.chop ##1 BEAT_VALID_O)
        else $error("fixed eight length wrong");
    no_cke_cmd_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        !CKE_I |=> !bus.start && !DLL_RESET_O)
        else $error("command taken with clock enable low");
    rd_once_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        !REG_RD_I |=> REG_RDATA_O == '0)
        else $error("read data outside its cycle");

endmodule

// ---- shared/sims_burst_if.sv ----
// Purpose: carrier between the command decoder and the burst sequencer
// Assumes: all signals are flip-flop outputs of the driving module
// Notes:   ctl drives the burst request, seq drives the beat outputs
`timescale 1ns/1ps
interface sims_burst_if;
    logic       start;
    logic       is_read;
    logic       chop;
    logic       interleave;
    logic [2:0] col;
    logic       valid;
    logic [2:0] beat_col;
    logic       drive;
    logic       take;

    modport ctl (output start, is_read, chop, interleave, col, input valid, beat_col, drive, take);
    modport seq (input start, is_read, chop, interleave, col, output valid, beat_col, drive, take);
endinterface

// ---- shared/sims_pkg.sv ----
// Purpose: shared constants and state types for the DRAM init and mode-set block
// Assumes: one core clock, command pins sampled on its rising edge
// Notes:   register map, mode-register field positions and burst encodings
package sims_pkg;

    // ************************************************************
    // widths and register map
    // ************************************************************
    localparam int         ADDR_W      = 14;
    localparam int         REG_AW      = 8;
    localparam int         REG_DW      = 32;
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_MODE_ZERO  = 8'h08;
    localparam logic [7:0] OFF_MODE_ONE   = 8'h0C;
    localparam logic [7:0] OFF_MODE_TWO   = 8'h10;
    localparam logic [7:0] OFF_MODE_THREE = 8'h14;

    // control and status bit positions
    localparam int         CTRL_CHECK_BIT = 0;
    localparam logic       CTRL_CHECK_RST = 1'b1;
    localparam int         STAT_TERM_BIT  = 0;
    localparam int         STAT_ERR_BIT   = 1;
    localparam int         STAT_DLL_BIT   = 2;
    localparam int         STAT_CKE_BIT   = 3;
    localparam int         STAT_WR_LSB    = 4;

    // ************************************************************
    // mode register selects and fields
    // ************************************************************
    localparam logic [1:0] SEL_ZERO    = 2'h0;
    localparam logic [1:0] SEL_ONE     = 2'h1;
    localparam logic [1:0] SEL_TWO     = 2'h2;
    localparam logic [1:0] SEL_THREE   = 2'h3;
    localparam int         BA_RSV_BIT  = 2;
    localparam int         BL_LSB      = 0;
    localparam int         BT_BIT      = 3;
    localparam int         DLL_RST_BIT = 8;
    localparam int         RSV_TOP_BIT = 13;
    localparam int         DLL_OFF_BIT = 0;
    localparam int         CHOP_SEL_BIT = 12;
    localparam logic [1:0] BL_FIXED8   = 2'h0;
    localparam logic [1:0] BL_OTF      = 2'h1;
    localparam logic [1:0] BL_FIXED4   = 2'h2;
    localparam logic [2:0] LAST_BEAT   = 3'h7;

    // ************************************************************
    // state types
    // ************************************************************
    typedef struct packed {
        logic                   cke_seen;
        logic                   term;
        logic [3:0][ADDR_W-1:0] mr;
        logic [3:0]             written;
        logic                   dll_en;
        logic                   dll_rst;
        logic                   err;
        logic                   check_en;
        logic [REG_DW-1:0]      rdata;
        logic                   start;
        logic                   is_read;
        logic                   chop;
        logic                   interleave;
        logic [2:0]             col;
    } sims_ctl_t;

    typedef struct packed {
        logic       run;
        logic [2:0] cnt;
        logic       read;
        logic       chop;
        logic       interleave;
        logic [2:0] base;
        logic       valid;
        logic [2:0] beat_col;
        logic       drive;
        logic       take;
    } sims_seq_t;

endpackage

// ---- sim/sims_ctrl_model.sv ----
// Purpose: controller-side model driving clock enable, termination and command pins
// Assumes: all outputs change by non-blocking assignment just after a rising edge
// Notes:   sequence intervals are short cycle counts chosen for simulation speed
`timescale 1ns/1ps
module sims_ctrl_model
    import sims_pkg::*;
#(
    parameter int RESET_EXIT_CYC = 5,
    parameter int MODE_UPD_CYC   = 12,
    parameter int LOCK_CYC       = 64
)
(
    input  wire logic         clk_i,
    output logic              cke_o,
    output logic              term_o,
    output logic [3:0]        cmd_n_o,
    output logic [2:0]        ba_o,
    output logic [ADDR_W-1:0] addr_o
);
    // clock enable low and pins deselected from power-up
    initial
    begin
        cke_o = 1'b0;
        term_o = 1'b1;
        cmd_n_o = 4'hF;
        ba_o = 3'h0;
        addr_o = '0;
    end

    // one command cycle, then no-operation with the bus lines showing the inverse
    task cmd(input logic [3:0] c, input logic [2:0] b, input logic [ADDR_W-1:0] a);
        @(posedge clk_i);
        cmd_n_o <= c;
        ba_o <= b;
        addr_o <= a;
        @(posedge clk_i);
        cmd_n_o <= 4'h7;
        ba_o <= ~b;
        addr_o <= ~a;
    endtask

    // mode set followed by the update delay, which also covers the cycle time
    task mode_set(input logic [2:0] b, input logic [ADDR_W-1:0] a);
        cmd(4'h0, b, a);
        repeat (MODE_UPD_CYC) @(posedge clk_i);
    endtask

    task cke_low;
        @(posedge clk_i);
        cke_o <= 1'b0;
    endtask

    // full start-up: idle, clock enable, reset-exit wait, four mode sets, calibration
    task power_up(input logic [ADDR_W-1:0] m2, m3, m1, m0);
        @(posedge clk_i);
        cmd_n_o <= 4'h7;
        repeat (5) @(posedge clk_i);
        cke_o <= 1'b1;
        repeat (RESET_EXIT_CYC) @(posedge clk_i);
        mode_set({1'b0, SEL_TWO}, m2);
        mode_set({1'b0, SEL_THREE}, m3);
        mode_set({1'b0, SEL_ONE}, m1);
        mode_set({1'b0, SEL_ZERO}, m0);
        cmd(4'h6, 3'h0, 14'h0400);
        repeat (LOCK_CYC) @(posedge clk_i);
    endtask
endmodule

// ---- sim/sims_top_bench.sv ----
// Purpose: self-checking bench for the DRAM init and mode-set block
// Assumes: controller model drives the command side, bench drives the register port
// Notes:   beat and read results are queued by the driver and checked by monitors
`timescale 1ns/1ps
module sims_top_bench;
    import sims_pkg::*;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, rst_d = 0, seen_v = 0, term_exp = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rdata;
    logic term_act, dll_en, dll_rst, beat_v, beat_drv, beat_take, cke, term;
    logic [2:0] beat_col, ba;
    logic [3:0] cmd_n;
    logic [ADDR_W-1:0] addr, m1, m2;
    logic [9:0] beat_e;
    logic [31:0] rd_q[$];
    logic [9:0] beat_q[$];
    int checked = 0, miscompares = 0, cycles = 0, dll_pulses = 0;

    sims_ctrl_model ctl (.clk_i(clk), .cke_o(cke), .term_o(term), .cmd_n_o(cmd_n), .ba_o(ba), .addr_o(addr));
    sims_top dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .CKE_I(cke), .TERM_CTRL_I(term), .CS_N_I(cmd_n[3]),
        .RAS_N_I(cmd_n[2]), .CAS_N_I(cmd_n[1]), .WE_N_I(cmd_n[0]), .BA_I(ba), .ADDR_I(addr),
        .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
        .REG_RDATA_O(rdata), .TERM_ACTIVE_O(term_act), .DLL_ENABLE_O(dll_en), .DLL_RESET_O(dll_rst),
        .BEAT_VALID_O(beat_v), .BEAT_COL_O(beat_col), .BEAT_DRIVE_O(beat_drv), .BEAT_TAKE_O(beat_take));

    initial
    begin
        forever #4 clk = ~clk;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ************************************************************
    // register port and burst drivers
    // ************************************************************
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(exp);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // note each beat as {care mask, drive, take, column}, then issue the command
    task burst(input logic rd, input logic [2:0] s, input logic ilv, input logic chop, input logic a12);
        logic [2:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = ilv ? s ^ i[2:0] : {s[2] ^ i[2], s[1:0] + i[1:0]};
            if (!rd)
                c = chop ? {s[2], i[1:0]} : i[2:0];
            else if (chop)
                c[2] = s[2];
            beat_q.push_back((chop && i > 3) ? 10'h300 : {5'h1F, rd, ~rd, c});
        end
        ctl.cmd(rd ? 4'h5 : 4'h4, 3'h1, {1'b0, a12, 9'h0, s});
        repeat (10) @(posedge clk);
    endtask

    // ************************************************************
    // monitors
    // ************************************************************
    // compare queued notes as results appear, and follow termination cycle by cycle
    always @(posedge clk)
    begin
        cycles++;
        if (rd_d)
            check("read data", rdata, rd_q.pop_front());
        rd_d <= reg_rd;
        if (beat_v === 1'b1)
        begin
            check("beat queued", beat_q.size() != 0, 1);
            beat_e = beat_q.pop_front();
            check("beat", {27'h0, {beat_drv, beat_take, beat_col} & beat_e[9:5]}, {27'h0, beat_e[4:0]});
        end
        if (rst_d)
            check("termination", term_act, term_exp);
        seen_v = rst_n & (seen_v | cke);
        term_exp <= seen_v & term;
        rst_d <= rst_n;
        if (dll_rst === 1'b1)
            dll_pulses++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test;
        end
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial
    begin
        void'($urandom(59));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(OFF_CTRL, 32'h1);
        reg_read(OFF_STATUS, 32'h0);
        m2 = 14'($urandom);
        m1 = 14'($urandom) & 14'h18BA;
        ctl.power_up(m2, 14'h0003, m1, 14'h0500);
        check("dll reset pulses", dll_pulses, 1);
        check("dll enable", dll_en, 1);
        reg_read(OFF_STATUS, 32'hFD);
        reg_read(OFF_MODE_TWO, {18'h0, m2});
        reg_read(OFF_MODE_ONE, {18'h0, m1});
        reg_read(8'h40, 32'h0);
        $display("test init done");
        ctl.mode_set(3'h6, 14'h1234);
        reg_read(OFF_MODE_TWO, {18'h0, m2});
        reg_read(OFF_STATUS, 32'hFF);
        reg_write(OFF_STATUS, 32'h2);
        ctl.mode_set(3'h0, 14'h2000);
        reg_read(OFF_STATUS, 32'hFF);
        reg_read(OFF_MODE_ZERO, 32'h2000);
        reg_write(OFF_STATUS, 32'h2);
        reg_write(OFF_CTRL, 32'h0);
        ctl.mode_set(3'h6, 14'h1234);
        reg_read(OFF_STATUS, 32'hFD);
        $display("test reserved bank done");
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 4; k++)
            begin
                ctl.mode_set(3'h0, {10'h0, k[0], 1'b0, m[1:0]});
                burst(!k[1] | k[0] & 1'($urandom), k == 1 ? 3'h5 : 3'($urandom),
                    k[0], m == 2 || (m == 1 && !k[1]), k[1]);
            end
        check("beats left", beat_q.size(), 0);
        check("dll reset pulses", dll_pulses, 1);
        $display("test bursts done");
        ctl.cke_low();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (13) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(OFF_STATUS, 32'h0);
        reg_read(OFF_MODE_ONE, 32'h0);
        ctl.power_up(m2, 14'h0003, m1, 14'h0500);
        reg_read(OFF_STATUS, 32'hFD);
        repeat (3) @(posedge clk);
        $display("test warm reset done");
        finish_test;
    end
endmodule
